// ===== core/ubc_pkg.sv
// Constants and carriers for the utility chip select B decode block
package ubc_pkg;
    // Register map
    localparam logic [7:0]  REG_OFS     = 8'h4F;
    localparam logic [7:0]  REG_RST     = 8'h4F;
    localparam logic [7:0]  RD_IDLE     = 8'h00;
    // Field positions in the control register
    localparam int          CFG_BIT     = 7;
    localparam int          P92_BIT     = 6;
    localparam int          LPT_LSB     = 4;
    localparam int          COMB_LSB    = 2;
    localparam int          COMA_LSB    = 0;
    // Two-bit field selections
    localparam logic [1:0]  SEL_0       = 2'h0;
    localparam logic [1:0]  SEL_1       = 2'h1;
    localparam logic [1:0]  SEL_2       = 2'h2;
    localparam logic [1:0]  SEL_OFF     = 2'h3;
    // I/O address windows: base and don't-care mask
    localparam logic [15:0] CPAGE_ADDR  = 16'h0C00;
    localparam logic [15:0] CMEM_BASE   = 16'h0800;
    localparam logic [15:0] CMEM_MASK   = 16'h00FF;
    localparam logic [15:0] P92_ADDR    = 16'h0092;
    localparam logic [15:0] LPT1_BASE   = 16'h03BC;
    localparam logic [15:0] LPT1_MASK   = 16'h0003;
    localparam logic [15:0] LPT2_BASE   = 16'h0378;
    localparam logic [15:0] LPT3_BASE   = 16'h0278;
    localparam logic [15:0] COM1_BASE   = 16'h03F8;
    localparam logic [15:0] COM2_BASE   = 16'h02F8;
    localparam logic [15:0] OCT_MASK    = 16'h0007;
    localparam logic [15:0] EXACT_MASK  = 16'h0000;
    // Encoded chip select codes
    localparam logic [2:0]  CS_NONE     = 3'h7;
    localparam logic [2:0]  CS_CPAGE    = 3'h0;
    localparam logic [2:0]  CS_CMEM     = 3'h1;
    localparam logic [2:0]  CS_P92      = 3'h2;
    localparam logic [2:0]  CS_LPT      = 3'h3;
    localparam logic [2:0]  CS_COMA     = 3'h4;
    localparam logic [2:0]  CS_COMB     = 3'h5;

    // One I/O cycle seen by the decoder
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
    } ubc_io_t;

    // Decoded chip select toward the utility bus
    typedef struct packed {
        logic [2:0] code;
        logic       hit;
    } ubc_cs_t;
endpackage

// ===== core/ubc_decode.sv
// Utility bus chip select B control register and I/O address decoder
// Notes on behaviour
// [RULE1] Config bit set: I/O write to 0C00h yields the config page code.
// [RULE2] Config bit set: I/O read or write 0800-08FFh yields memory code.
// [RULE3] Config bit clear: neither config page nor config memory code.
// [RULE4] Bit 6 enables the port 92h decode; zero disables it.
// [RULE5] Parallel field: 3BCh, 378h, 278h ranges, or disabled.
// [RULE6] Reset loads parallel field with 00.
// [RULE7] Serial B field: 3F8h, 2F8h, reserved, or disabled.
// [RULE8] Reset loads serial B field with 11.
// [RULE9] Serial A and B on same range: B code suppressed, A kept.
// [RULE10] Disabled peripheral gets no code and no transceiver enable.
// [RULE11] Serial A field: 3F8h, 2F8h, reserved, disabled; reset loads 11.
// [RULE12] Reserved serial B code behaves as disabled.
`timescale 1ns/1ps
module ubc_decode (
    input  wire logic             core_clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [7:0]       reg_addr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             reg_wr_in,
    input  wire logic             reg_rd_in,
    output logic [7:0]            reg_rdata_out,
    input  wire ubc_pkg::ubc_io_t io_in,
    output ubc_pkg::ubc_cs_t      cs_out,
    output logic                  utility_transceiver_output_enable_n_out
);

    logic [7:0]       ctrl_reg;
    logic [7:0]       ctrl_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    ubc_pkg::ubc_cs_t cs_reg;
    ubc_pkg::ubc_cs_t cs_next;
    logic             oe_n_reg;
    logic             oe_n_next;
    logic             cfg_en;
    logic             p92_en;
    logic [1:0]       lpt_sel;
    logic [1:0]       comb_sel;
    logic [1:0]       coma_sel;
    logic             io_acc;
    logic             lpt_hit;
    logic             coma_hit;
    logic             comb_hit;

    // Address window match; mask bits are don't-care
    function automatic logic in_win(input logic [15:0] a,
                                    input logic [15:0] base,
                                    input logic [15:0] mask);
        in_win = (a & ~mask) == base;
    endfunction

    // Serial range select shared by both ports
    function automatic logic com_win(input logic [1:0]  sel,
                                     input logic [15:0] a);
        com_win = 1'b0;
        if (sel == ubc_pkg::SEL_0) begin
            com_win = in_win(a, ubc_pkg::COM1_BASE, ubc_pkg::OCT_MASK);
        end else if (sel == ubc_pkg::SEL_1) begin
            com_win = in_win(a, ubc_pkg::COM2_BASE, ubc_pkg::OCT_MASK);
        end
    endfunction

    // Field extraction
    assign cfg_en   = ctrl_reg[ubc_pkg::CFG_BIT];
    assign p92_en   = ctrl_reg[ubc_pkg::P92_BIT];
    assign lpt_sel  = ctrl_reg[ubc_pkg::LPT_LSB +: 2];
    assign comb_sel = ctrl_reg[ubc_pkg::COMB_LSB +: 2];
    assign coma_sel = ctrl_reg[ubc_pkg::COMA_LSB +: 2];
    assign io_acc   = io_in.rd | io_in.wr;

    // Register write and read-back path
    always_comb begin
        ctrl_next  = ctrl_reg;
        rdata_next = ubc_pkg::RD_IDLE;
        if (reg_wr_in && reg_addr_in == ubc_pkg::REG_OFS) begin
            ctrl_next = reg_wdata_in;
        end
        if (reg_rd_in && reg_addr_in == ubc_pkg::REG_OFS) begin
            rdata_next = ctrl_reg;
        end
    end

    // Reset puts parallel at 00 and both serial ports off
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_reg  <= ubc_pkg::REG_RST; // RULE6 RULE8 RULE11
            rdata_reg <= ubc_pkg::RD_IDLE;
        end else begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // Parallel port range; 11 yields no match
    always_comb begin
        unique case (lpt_sel)
            ubc_pkg::SEL_0: lpt_hit = in_win(io_in.addr,
                ubc_pkg::LPT1_BASE, ubc_pkg::LPT1_MASK); // RULE5
            ubc_pkg::SEL_1: lpt_hit = in_win(io_in.addr,
                ubc_pkg::LPT2_BASE, ubc_pkg::OCT_MASK);
            ubc_pkg::SEL_2: lpt_hit = in_win(io_in.addr,
                ubc_pkg::LPT3_BASE, ubc_pkg::OCT_MASK);
            ubc_pkg::SEL_OFF: lpt_hit = 1'b0;
        endcase
    end

    // Serial ports; reserved code matches nothing, B yields to A
    assign coma_hit = com_win(coma_sel, io_in.addr); // RULE11
    assign comb_hit = com_win(comb_sel, io_in.addr) // RULE7 RULE12
                      && (comb_sel != coma_sel); // RULE9

    // Chip select decode; fixed priority keeps one code per cycle
    always_comb begin
        cs_next.hit  = 1'b0;
        cs_next.code = ubc_pkg::CS_NONE;
        if (cfg_en && io_in.wr
            && io_in.addr == ubc_pkg::CPAGE_ADDR) begin // RULE1 RULE3
            cs_next.hit  = 1'b1;
            cs_next.code = ubc_pkg::CS_CPAGE;
        end else if (cfg_en && io_acc && in_win(io_in.addr,
                     ubc_pkg::CMEM_BASE, ubc_pkg::CMEM_MASK)) begin // RULE2
            cs_next.hit  = 1'b1;
            cs_next.code = ubc_pkg::CS_CMEM;
        end else if (p92_en && io_acc && in_win(io_in.addr,
                     ubc_pkg::P92_ADDR, ubc_pkg::EXACT_MASK)) begin // RULE4
            cs_next.hit  = 1'b1;
            cs_next.code = ubc_pkg::CS_P92;
        end else if (io_acc && lpt_hit) begin
            cs_next.hit  = 1'b1;
            cs_next.code = ubc_pkg::CS_LPT;
        end else if (io_acc && coma_hit) begin
            cs_next.hit  = 1'b1;
            cs_next.code = ubc_pkg::CS_COMA;
        end else if (io_acc && comb_hit) begin
            cs_next.hit  = 1'b1;
            cs_next.code = ubc_pkg::CS_COMB;
        end
    end

    // Transceiver opens only for a decoded chip select
    assign oe_n_next = ~cs_next.hit; // RULE10

    // Outputs registered so the utility bus sees glitch-free codes
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs_reg.hit  <= 1'b0;
            cs_reg.code <= ubc_pkg::CS_NONE;
            oe_n_reg    <= 1'b1;
        end else begin
            cs_reg   <= cs_next;
            oe_n_reg <= oe_n_next; // RULE10
        end
    end

    assign cs_out        = cs_reg;
    assign reg_rdata_out = rdata_reg;
    assign utility_transceiver_output_enable_n_out = oe_n_reg;

    // Tracks whether software has written the register since reset
    logic wr_seen_reg;
    logic wr_seen_next;

    // Sticky once a mapped write lands; writes elsewhere leave it alone
    always_comb begin
        wr_seen_next = wr_seen_reg;
        if (reg_wr_in && reg_addr_in == ubc_pkg::REG_OFS) begin
            wr_seen_next = 1'b1;
        end
    end

    // Only reset clears the write marker
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_seen_reg <= 1'b0;
        end else begin
            wr_seen_reg <= wr_seen_next;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_cpage;
        cfg_en && io_in.wr && io_in.addr == ubc_pkg::CPAGE_ADDR
            |=> cs_out.hit && cs_out.code == ubc_pkg::CS_CPAGE;
    endproperty
    a_cpage: assert property (p_cpage) // RULE1
        else $error("config page code missing");

    property p_cmem;
        cfg_en && io_acc && io_in.addr[15:8] == ubc_pkg::CMEM_BASE[15:8]
            && io_in.addr != ubc_pkg::CPAGE_ADDR
            |=> cs_out.code == ubc_pkg::CS_CMEM;
    endproperty
    a_cmem: assert property (p_cmem) // RULE2
        else $error("config memory code missing");

    property p_cfg_off;
        !cfg_en |=> cs_out.code != ubc_pkg::CS_CPAGE
                    && cs_out.code != ubc_pkg::CS_CMEM;
    endproperty
    a_cfg_off: assert property (p_cfg_off) // RULE3
        else $error("config code while disabled");

    property p_p92;
        io_acc && io_in.addr == ubc_pkg::P92_ADDR
            |=> (cs_out.code == ubc_pkg::CS_P92) == $past(p92_en);
    endproperty
    a_p92: assert property (p_p92) // RULE4
        else $error("port 92 decode wrong");

    property p_lpt_off;
        lpt_sel == ubc_pkg::SEL_OFF |=> cs_out.code != ubc_pkg::CS_LPT;
    endproperty
    a_lpt_off: assert property (p_lpt_off) // RULE5
        else $error("parallel code while disabled");

    property p_reset_val;
        !wr_seen_reg |-> ctrl_reg == ubc_pkg::REG_RST;
    endproperty
    a_reset_val: assert property (p_reset_val) // RULE6 RULE8 RULE11
        else $error("control register left reset value");

    property p_comb_clash;
        comb_sel == coma_sel && coma_sel != ubc_pkg::SEL_OFF
            |=> cs_out.code != ubc_pkg::CS_COMB;
    endproperty
    a_comb_clash: assert property (p_comb_clash) // RULE9
        else $error("serial B code on shared range");

    property p_oe;
        utility_transceiver_output_enable_n_out == !cs_out.hit;
    endproperty
    a_oe: assert property (p_oe) // RULE10
        else $error("transceiver enable without chip select");

    property p_comb_rsv;
        comb_sel == ubc_pkg::SEL_2 |=> cs_out.code != ubc_pkg::CS_COMB;
    endproperty
    a_comb_rsv: assert property (p_comb_rsv) // RULE12
        else $error("serial B code on reserved select");

    // No higher-priority window overlaps the serial ranges
    property p_comb_on;
        comb_sel == ubc_pkg::SEL_1 && coma_sel != ubc_pkg::SEL_1 && io_acc
            && in_win(io_in.addr, ubc_pkg::COM2_BASE, ubc_pkg::OCT_MASK)
            |=> cs_out.code == ubc_pkg::CS_COMB;
    endproperty
    a_comb_on: assert property (p_comb_on) // RULE7
        else $error("serial B code missing");

    property p_rdback;
        reg_rd_in && reg_addr_in == ubc_pkg::REG_OFS
            |=> reg_rdata_out == $past(ctrl_reg);
    endproperty
    a_rdback: assert property (p_rdback)
        else $error("read data mismatch");

    property p_comb_off;
        comb_sel == ubc_pkg::SEL_OFF |=> cs_out.code != ubc_pkg::CS_COMB;
    endproperty
    a_comb_off: assert property (p_comb_off) // RULE7 RULE10
        else $error("serial B code while disabled");

    property p_coma_off;
        coma_sel == ubc_pkg::SEL_OFF || coma_sel == ubc_pkg::SEL_2
            |=> cs_out.code != ubc_pkg::CS_COMA;
    endproperty
    a_coma_off: assert property (p_coma_off) // RULE11
        else $error("serial A code while disabled");

    // Port A keeps its code even when port B shares the range
    property p_coma_on;
        coma_sel == ubc_pkg::SEL_0 && io_acc
            && in_win(io_in.addr, ubc_pkg::COM1_BASE, ubc_pkg::OCT_MASK)
            |=> cs_out.code == ubc_pkg::CS_COMA;
    endproperty
    a_coma_on: assert property (p_coma_on) // RULE9 RULE11
        else $error("serial A code missing");

    property p_lpt_on;
        lpt_sel == ubc_pkg::SEL_1 && io_acc
            && in_win(io_in.addr, ubc_pkg::LPT2_BASE, ubc_pkg::OCT_MASK)
            |=> cs_out.code == ubc_pkg::CS_LPT;
    endproperty
    a_lpt_on: assert property (p_lpt_on) // RULE5
        else $error("parallel code missing");

    property p_hit_code;
        cs_out.hit == (cs_out.code != ubc_pkg::CS_NONE);
    endproperty
    a_hit_code: assert property (p_hit_code) // RULE10
        else $error("chip select flag and code disagree");

    // Config page select answers writes only
    property p_cpage_rd;
        io_in.rd && !io_in.wr && io_in.addr == ubc_pkg::CPAGE_ADDR
            |=> cs_out.code != ubc_pkg::CS_CPAGE;
    endproperty
    a_cpage_rd: assert property (p_cpage_rd) // RULE1
        else $error("config page code on a read");

    property p_rd_idle;
        !(reg_rd_in && reg_addr_in == ubc_pkg::REG_OFS)
            |=> reg_rdata_out == ubc_pkg::RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside the read slot");

    c_cmem:  cover property (cs_out.code == ubc_pkg::CS_CMEM);
    c_cpage: cover property (cs_out.code == ubc_pkg::CS_CPAGE);
    c_lpt:   cover property (cs_out.code == ubc_pkg::CS_LPT);
    c_coma:  cover property (cs_out.code == ubc_pkg::CS_COMA);
    c_comb:  cover property (cs_out.code == ubc_pkg::CS_COMB);

endmodule

// ===== tb/ubc_periph_model.sv
// Utility bus peripheral side: external decoder of the chip select code
`timescale 1ns/1ps
module ubc_periph_model (
    input  wire ubc_pkg::ubc_cs_t cs_in,
    input  wire logic             oe_n_in,
    output logic [7:0]            sel_n_out
);
    // Selects only while the transceiver is on, so stray codes stay harmless
    always_comb begin
        sel_n_out = 8'hFF;
        if (!oe_n_in) begin
            sel_n_out[cs_in.code] = 1'b0;
        end
    end
endmodule

// ===== tb/ubc_decode_tb.sv
// Self-checking bench for the chip select B control register and decoder
`timescale 1ns/1ps
module ubc_decode_tb;
    logic             clk;
    logic             rst_n;
    logic             wr;
    logic             rd;
    logic [7:0]       addr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic [7:0]       sel_n;
    logic [7:0]       ctrl;
    logic             oe_n;
    ubc_pkg::ubc_io_t io;
    ubc_pkg::ubc_cs_t cs;
    int               error_cnt;
    int               checks_done;
    int               cyc;
    // Control values cover every field code, reserved codes and A/B clashes
    logic [7:0]  ctrl_tab [8] = '{8'h4F, 8'h80, 8'hD1, 8'hA4,
                                  8'h38, 8'h73, 8'h46, 8'h05};
    // Window edges, plus the addresses just past the 08FFh, 0092h, 03BFh and 03FFh edges
    logic [15:0] addr_tab [18] = '{16'h0C00, 16'h0800, 16'h08FF, 16'h0900,
        16'h0092, 16'h0093, 16'h03BC, 16'h03BF, 16'h03C0, 16'h0378,
        16'h037F, 16'h0278, 16'h027F, 16'h03F8, 16'h03FF, 16'h02F8,
        16'h02FF, 16'h0400};

    ubc_decode dut (
        .core_clk_in                             (clk),
        .arst_n_in                               (rst_n),
        .reg_addr_in                             (addr),
        .reg_wdata_in                            (wdata),
        .reg_wr_in                               (wr),
        .reg_rd_in                               (rd),
        .reg_rdata_out                           (rdata),
        .io_in                                   (io),
        .cs_out                                  (cs),
        .utility_transceiver_output_enable_n_out (oe_n)
    );

    ubc_periph_model periph (
        .cs_in     (cs),
        .oe_n_in   (oe_n),
        .sel_n_out (sel_n)
    );

    // Serial window of one field code; reserved and off match nothing
    function automatic logic com_hit(logic [1:0] f, logic [15:0] a);
        if (f == 2'h0) return (a & ~16'h0007) == 16'h03F8;
        if (f == 2'h1) return (a & ~16'h0007) == 16'h02F8;
        return 1'b0;
    endfunction

    // Expected {code, hit} in priority order
    function automatic logic [3:0] exp_cs(logic [7:0] c, logic [15:0] a,
                                          logic r, logic w);
        logic any;
        any = r | w;
        if (c[7] && w && a == 16'h0C00) return 4'h1;
        if (c[7] && any && a[15:8] == 8'h08) return 4'h3;
        if (c[6] && any && a == 16'h0092) return 4'h5;
        if (any && c[5:4] == 2'h0 && (a & ~16'h0003) == 16'h03BC)
            return 4'h7;
        if (any && c[5:4] == 2'h1 && (a & ~16'h0007) == 16'h0378)
            return 4'h7;
        if (any && c[5:4] == 2'h2 && (a & ~16'h0007) == 16'h0278)
            return 4'h7;
        if (any && com_hit(c[1:0], a)) return 4'h9;
        if (any && c[3:2] != c[1:0] && com_hit(c[3:2], a)) return 4'hB;
        return 4'hE;
    endfunction

    task automatic check(input logic [15:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, "rdata");
    endtask

    // One I/O cycle, outputs judged one cycle later
    task automatic io_cyc(input logic [15:0] a, input logic r, w);
        logic [3:0] e;
        logic [7:0] s;
        e = exp_cs(ctrl, a, r, w);
        // Mask built at eight bits so the upper byte stays clear
        s = e[0] ? ~(8'h01 << e[3:1]) : 8'hFF;
        @(posedge clk);
        io <= '{addr: a, rd: r, wr: w};
        @(posedge clk);
        io <= '{addr: 16'h0000, rd: 1'b0, wr: 1'b0};
        #1;
        check(cs.code, e[3:1], "code");
        check(cs.hit, e[0], "hit");
        check(oe_n, !e[0], "oe_n");
        check(sel_n, s, "sel");
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard, well above the roughly 920 cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        io = '0;
        ctrl = 8'h4F;
        error_cnt = 0;
        checks_done = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(8'h4F, 8'h4F);
        reg_wr(8'h4E, 8'h00);
        reg_rd(8'h4E, 8'h00);
        reg_rd(8'h4F, 8'h4F);
        foreach (ctrl_tab[i]) begin
            reg_wr(8'h4F, ctrl_tab[i]);
            ctrl = ctrl_tab[i];
            reg_rd(8'h4F, ctrl);
            foreach (addr_tab[j]) begin
                io_cyc(addr_tab[j], 1'b1, 1'b0);
                io_cyc(addr_tab[j], 1'b0, 1'b1);
                io_cyc(addr_tab[j], 1'b0, 1'b0);
            end
        end
        // Reset in mid-run must restore the defaults
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        ctrl = 8'h4F;
        reg_rd(8'h4F, 8'h4F);
        io_cyc(16'h03F8, 1'b1, 1'b0);
        wrap_up();
    end
endmodule
